// File: core/esdd_map.svh
// Constants for the emergency-stop and servo-disable delay block
// ===========================================================
// Notes on behaviour
// - Immediate-stop fault starts axis disable delay
// - Withdrawn enable request starts disable delay
// - Delay running: standstill drops servo enable
// - Expiry drops enable; 0.1 s, 0.02..1000
// - Already stationary at trigger: drop at once
// - Early drop while moving forces setpoint zero
// - High request enters emergency-stop condition
// - Low request alone does not clear condition
// - Clear needs acknowledge first, then reset
// - Reset without acknowledge changes nothing
// - Clear restores enable, ready, alarm, abort
`ifndef ESDD_MAP_SVH
`define ESDD_MAP_SVH

// ===========================================================
// Delay limits, in milliseconds
`define ESDD_DELAY_DEF_MS 20'd100
`define ESDD_DELAY_MIN_MS 20'd20
`define ESDD_DELAY_MAX_MS 20'd1000000

// ===========================================================
// Controller tick period and conversion
`define ESDD_US_PER_MS    32'd1000
`define ESDD_TICK_US      32'd1000
`define ESDD_DELAY_W      20

`endif

// File: core/esdd_pkg.sv
// Types shared by the emergency-stop and servo-disable delay block
`default_nettype none
package esdd_pkg;

    // =======================================================
    // Signal groups
    typedef struct packed {
        logic request;
        logic acknowledge;
        logic reset;
    } esdd_plc_in_t;

    typedef struct packed {
        logic active;
        logic ready;
        logic pos_ctrl;
        logic alarm;
    } esdd_nc_status_t;

    // =======================================================
    // State types
    typedef enum logic [1:0] {
        ESDD_ES_IDLE   = 2'h0,
        ESDD_ES_ACTIVE = 2'h1,
        ESDD_ES_ACKED  = 2'h3
    } esdd_es_state_t;

    typedef enum logic [1:0] {
        ESDD_AX_OFF   = 2'h0,
        ESDD_AX_ON    = 2'h1,
        ESDD_AX_DELAY = 2'h3
    } esdd_ax_state_t;

endpackage
`default_nettype wire

// File: core/esdd_axis_delay.sv
// Per-axis servo enable with delayed withdrawal after faults
`default_nettype none
`include "esdd_map.svh"
module esdd_axis_delay #(
    parameter int SPEED_W = 16
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    // Controller cycle and configuration
    input  wire logic                      ctrl_tick,
    input  wire logic [`ESDD_DELAY_W-1:0]  delay_ticks,
    // Axis inputs
    input  wire logic                      fault_stop,
    input  wire logic                      enable_request,
    input  wire logic                      standstill,
    // Drive outputs
    output logic                           servo_enable,
    output logic                           setpoint_zero,
    output logic                           delay_running
);
    import esdd_pkg::*;

    // =======================================================
    // State and decode
    esdd_ax_state_t             state_r;
    esdd_ax_state_t             state_nxt;
    logic [`ESDD_DELAY_W-1:0]   cnt_r;
    logic                       fault_prev_r;
    logic                       req_prev_r;
    logic                       servo_en_r;
    logic                       zero_r;
    wire logic fault_rise = fault_stop & ~fault_prev_r;
    wire logic req_fall   = req_prev_r & ~enable_request;
    wire logic trigger    = fault_rise | req_fall;
    wire logic expired    = ctrl_tick && cnt_r <= `ESDD_DELAY_W'(1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ESDD_AX_OFF: begin
                if (enable_request && !fault_stop) begin
                    state_nxt = ESDD_AX_ON;
                end
            end
            ESDD_AX_ON: begin
                if (trigger) begin
                    state_nxt = standstill ? ESDD_AX_OFF
                                           : ESDD_AX_DELAY;
                end
            end
            ESDD_AX_DELAY: begin
                if (standstill || expired) begin
                    state_nxt = ESDD_AX_OFF;
                end
            end
            default: state_nxt = ESDD_AX_OFF;
        endcase
    end

    // =======================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r      <= ESDD_AX_OFF;
            cnt_r        <= '0;
            fault_prev_r <= 1'b0;
            req_prev_r   <= 1'b0;
            servo_en_r   <= 1'b0;
            zero_r       <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            fault_prev_r <= fault_stop;
            req_prev_r   <= enable_request;
            servo_en_r   <= state_nxt != ESDD_AX_OFF;
            if (state_r == ESDD_AX_ON) begin
                cnt_r <= delay_ticks;
            end else if (ctrl_tick && cnt_r != '0) begin
                cnt_r <= cnt_r - `ESDD_DELAY_W'(1);
            end
            // Abrupt stop: moving axis lost its enable early
            if (state_r == ESDD_AX_DELAY && expired && !standstill) begin
                zero_r <= 1'b1;
            end else if (state_nxt == ESDD_AX_ON) begin
                zero_r <= 1'b0;
            end
        end
    end

    assign servo_enable  = servo_en_r;
    assign setpoint_zero = zero_r;
    assign delay_running = state_r == ESDD_AX_DELAY;

    // =======================================================
    // Checks
    standstill_drop_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        state_r == ESDD_AX_DELAY && standstill |=> !servo_enable)
        else $error("enable kept at standstill during delay");
    expiry_zero_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        state_r == ESDD_AX_DELAY && expired && !standstill
        |=> !servo_enable && setpoint_zero)
        else $error("expiry while moving did not zero setpoint");
    immediate_drop_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        state_r == ESDD_AX_ON && trigger && standstill
        |=> !servo_enable && !delay_running)
        else $error("stationary axis not dropped at once");
    trigger_start_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        state_r == ESDD_AX_ON && trigger && !standstill
        |=> delay_running && servo_enable && cnt_r == $past(delay_ticks))
        else $error("trigger did not start delay");
    req_fall_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        state_r == ESDD_AX_ON && req_fall && !standstill |=> delay_running)
        else $error("withdrawn request did not start delay");
endmodule
`default_nettype wire

// File: core/esdd_top.sv
// Emergency-stop condition control and per-axis servo disable delay
`default_nettype none
`include "esdd_map.svh"
module esdd_top #(
    parameter int NUM_AXES = 4,
    parameter int SPEED_W  = 16
) (
    // Clock and reset
    input  wire logic                                 sys_clk,
    input  wire logic                                 sys_rst,
    // Controller cycle tick, one-cycle pulse
    input  wire logic                                 ctrl_tick,
    // Emergency-stop requests from the PLC program
    input  wire esdd_pkg::esdd_plc_in_t               plc_in,
    // Configuration
    input  wire logic [`ESDD_DELAY_W-1:0]             cfg_delay_ms,
    input  wire logic                                 config_apply,
    input  wire logic [SPEED_W-1:0]                   standstill_speed_band,
    // Axes and drives
    input  wire logic [NUM_AXES-1:0]                  axis_fault_stop,
    input  wire logic [NUM_AXES-1:0]                  drive_enable_request_bit,
    input  wire logic [NUM_AXES-1:0][SPEED_W-1:0]     actual_speed,
    output logic [NUM_AXES-1:0]                       servo_enable,
    output logic [NUM_AXES-1:0]                       setpoint_zero,
    output logic [NUM_AXES-1:0]                       delay_running,
    // Controller status
    output esdd_pkg::esdd_nc_status_t                 nc_status,
    output logic                                      program_interrupt,
    output logic                                      program_abort
);
    import esdd_pkg::*;

    // =======================================================
    // Elaboration checks
    if (NUM_AXES < 1 || SPEED_W < 2) begin : g_bad_param
        $error("esdd_top: NUM_AXES and SPEED_W out of range");
    end

    // =======================================================
    // Helpers
    function automatic logic in_band(input logic [SPEED_W-1:0] spd,
                                     input logic [SPEED_W-1:0] band);
        logic [SPEED_W-1:0] mag;
        mag = spd[SPEED_W-1] ? SPEED_W'(-spd) : spd;
        return mag <= band;
    endfunction

    function automatic logic [`ESDD_DELAY_W-1:0] ms_to_ticks(
        input logic [`ESDD_DELAY_W-1:0] ms);
        logic [`ESDD_DELAY_W-1:0] lim;
        logic [63:0]              t;
        lim = ms < `ESDD_DELAY_MIN_MS ? `ESDD_DELAY_MIN_MS :
              ms > `ESDD_DELAY_MAX_MS ? `ESDD_DELAY_MAX_MS : ms;
        t = (64'(lim) * 64'(`ESDD_US_PER_MS)) / 64'(`ESDD_TICK_US);
        if (t == 64'h0) begin
            t = 64'h1;
        end
        return t[`ESDD_DELAY_W-1:0];
    endfunction

    // =======================================================
    // Input synchronisers, pins from the PLC side
    logic [2:0]          plc_meta_r;
    logic [2:0]          plc_sync_r;
    logic [NUM_AXES-1:0] req_meta_r;
    logic [NUM_AXES-1:0] req_sync_r;
    logic [NUM_AXES-1:0] flt_meta_r;
    logic [NUM_AXES-1:0] flt_sync_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            plc_meta_r <= 3'h0;
            plc_sync_r <= 3'h0;
            req_meta_r <= '0;
            req_sync_r <= '0;
            flt_meta_r <= '0;
            flt_sync_r <= '0;
        end else begin
            plc_meta_r <= {plc_in.request, plc_in.acknowledge, plc_in.reset};
            plc_sync_r <= plc_meta_r;
            req_meta_r <= drive_enable_request_bit;
            req_sync_r <= req_meta_r;
            flt_meta_r <= axis_fault_stop;
            flt_sync_r <= flt_meta_r;
        end
    end

    wire logic req_s = plc_sync_r[2];
    wire logic ack_s = plc_sync_r[1];
    wire logic rst_s = plc_sync_r[0];

    // =======================================================
    // Emergency-stop condition
    // Levels only: a held request keeps re-entering, no edge needed
    esdd_es_state_t es_r;
    esdd_es_state_t es_nxt;
    logic           abort_r;
    logic           intr_r;
    logic           active_r;

    always_comb begin
        es_nxt = es_r;
        if (ctrl_tick) begin
            case (es_r)
                ESDD_ES_IDLE: begin
                    if (req_s) begin
                        es_nxt = ESDD_ES_ACTIVE;
                    end
                end
                ESDD_ES_ACTIVE: begin
                    // Reset seen here has no effect
                    if (ack_s && !req_s) begin
                        es_nxt = ESDD_ES_ACKED;
                    end
                end
                ESDD_ES_ACKED: begin
                    if (req_s || !ack_s) begin
                        es_nxt = ESDD_ES_ACTIVE;
                    end else if (rst_s) begin
                        es_nxt = ESDD_ES_IDLE;
                    end
                end
                default: es_nxt = ESDD_ES_ACTIVE;
            endcase
        end
    end

    wire logic es_clear = es_r == ESDD_ES_ACKED && es_nxt == ESDD_ES_IDLE;
    wire logic es_enter = es_r == ESDD_ES_IDLE && es_nxt != ESDD_ES_IDLE;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            es_r     <= ESDD_ES_IDLE;
            active_r <= 1'b0;
            abort_r  <= 1'b0;
            intr_r   <= 1'b0;
        end else begin
            es_r     <= es_nxt;
            active_r <= es_nxt != ESDD_ES_IDLE;
            abort_r  <= es_clear;
            intr_r   <= es_enter;
        end
    end

    // Ready, position control and alarm all follow the condition
    assign nc_status.active   = active_r;
    assign nc_status.ready    = ~active_r;
    assign nc_status.pos_ctrl = ~active_r;
    assign nc_status.alarm    = active_r;
    assign program_abort      = abort_r;
    assign program_interrupt  = intr_r;

    // =======================================================
    // Delay configuration
    // Takes effect only on apply, so a running delay is never
    // stretched or cut by an edit in progress
    logic [`ESDD_DELAY_W-1:0] delay_ticks_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            delay_ticks_r <= ms_to_ticks(`ESDD_DELAY_DEF_MS);
        end else if (config_apply) begin
            delay_ticks_r <= ms_to_ticks(cfg_delay_ms);
        end
    end

    // =======================================================
    // Axes
    // Emergency stop acts as an immediate-stop fault on every axis;
    // clearing it lets a held request restore the enable
    wire logic [NUM_AXES-1:0] stop_lvl = flt_sync_r | {NUM_AXES{active_r}};

    for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
        esdd_axis_delay #(
            .SPEED_W (SPEED_W)
        ) u_axis (
            .sys_clk        (sys_clk),
            .sys_rst        (sys_rst),
            .ctrl_tick      (ctrl_tick),
            .delay_ticks    (delay_ticks_r),
            .fault_stop     (stop_lvl[i]),
            .enable_request (req_sync_r[i]),
            .standstill     (in_band(actual_speed[i],
                                     standstill_speed_band)),
            .servo_enable   (servo_enable[i]),
            .setpoint_zero  (setpoint_zero[i]),
            .delay_running  (delay_running[i])
        );
    end

    // =======================================================
    // Checks
    entry_on_request_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        ctrl_tick && req_s |=> nc_status.active ##1 nc_status.active)
        else $error("request did not enter emergency stop");
    clear_sequence_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        $fell(active_r) |-> $past(ack_s) && $past(rst_s)
                            && $past(es_r) == ESDD_ES_ACKED)
        else $error("condition cleared without ack then reset");
    reset_alone_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        es_r == ESDD_ES_ACTIVE && rst_s && !ack_s
        |=> es_r == ESDD_ES_ACTIVE)
        else $error("reset alone cleared emergency stop");
    clear_effects_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        es_clear |=> program_abort && nc_status.ready
                     && nc_status.pos_ctrl && !nc_status.alarm)
        else $error("clearing effects missing");
    tick_sampled_a: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        !ctrl_tick |=> es_r == $past(es_r))
        else $error("condition changed between ticks");
endmodule
`default_nettype wire

// File: sim/esdd_drive_model.sv
// Behavioural axis drive model: speed source with fault brake ramp
`default_nettype none
module esdd_drive_model #(
    parameter int NUM_AXES = 4,
    parameter int SPEED_W  = 16,
    parameter int STEP     = 10
) (
    // Clock and reset
    input  wire logic                             sys_clk,
    input  wire logic                             sys_rst,
    input  wire logic                             ctrl_tick,
    // Drive control from the block
    input  wire logic [NUM_AXES-1:0]              servo_enable,
    input  wire logic [NUM_AXES-1:0]              setpoint_zero,
    // Bench commands
    input  wire logic [NUM_AXES-1:0]              speed_load,
    input  wire logic [NUM_AXES-1:0]              ramp_en,
    input  wire logic [NUM_AXES-1:0][SPEED_W-1:0] speed_set,
    // Measured speed
    output logic [NUM_AXES-1:0][SPEED_W-1:0]      actual_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    // =======================================================
    // Braking step toward zero, either direction
    function automatic logic [SPEED_W-1:0] brake(input logic [SPEED_W-1:0] v);
        int sv;
        sv = $signed(v);
        if (sv > STEP)
            sv = sv - STEP;
        else if (sv < -STEP)
            sv = sv + STEP;
        else
            sv = 0;
        return SPEED_W'(sv);
    endfunction

    // =======================================================
    // Speed state; braking needs the drive still enabled
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            actual_speed <= '0;
        end else begin
            for (int i = 0; i < NUM_AXES; i++) begin
                if (speed_load[i])
                    actual_speed[i] <= speed_set[i];
                else if (setpoint_zero[i])
                    actual_speed[i] <= '0;
                else if (ctrl_tick && ramp_en[i] && servo_enable[i])
                    actual_speed[i] <= brake(actual_speed[i]);
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the estop and servo disable delay block
`default_nettype none
module testbench
    import esdd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NA = 4;
    localparam int SW = 16;
    localparam int TD = 4;  // Clocks per controller tick, kept short
    // =======================================================
    // Stimulus and observed signals
    logic                   sys_clk      = 1'b0;
    logic                   sys_rst      = 1'b1;
    logic                   ctrl_tick    = 1'b0;
    logic [1:0]             tdiv         = 2'h0;
    esdd_plc_in_t           plc          = '0;
    logic [19:0]            cfg_ms       = 20'h00064;
    logic                   config_apply = 1'b0;
    logic [SW-1:0]          band         = 16'h0004;
    logic [NA-1:0]          fault        = 4'h0;
    logic [NA-1:0]          en_req       = 4'h0;
    logic [NA-1:0]          spd_load     = 4'h0;
    logic [NA-1:0][SW-1:0]  spd_set      = '0;
    logic [NA-1:0][SW-1:0]  speed;
    logic [NA-1:0]          servo_enable;
    logic [NA-1:0]          setpoint_zero;
    logic [NA-1:0]          delay_running;
    esdd_nc_status_t        nc_status;
    logic                   program_interrupt;
    logic                   program_abort;
    int                     errors          = 0;
    int                     samples_checked = 0;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tdiv <= tdiv + 2'h1;
        ctrl_tick <= (tdiv == 2'h3);
    end

    esdd_top #(.NUM_AXES(NA), .SPEED_W(SW)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .ctrl_tick(ctrl_tick),
        .plc_in(plc), .cfg_delay_ms(cfg_ms), .config_apply(config_apply),
        .standstill_speed_band(band), .axis_fault_stop(fault),
        .drive_enable_request_bit(en_req), .actual_speed(speed),
        .servo_enable(servo_enable), .setpoint_zero(setpoint_zero),
        .delay_running(delay_running), .nc_status(nc_status),
        .program_interrupt(program_interrupt),
        .program_abort(program_abort)
    );

    // Drive brakes on its own fault only
    esdd_drive_model #(.NUM_AXES(NA), .SPEED_W(SW)) drive_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .ctrl_tick(ctrl_tick),
        .servo_enable(servo_enable), .setpoint_zero(setpoint_zero),
        .speed_load(spd_load), .ramp_en(fault), .speed_set(spd_set),
        .actual_speed(speed)
    );

    // =======================================================
    // Shared tasks
    task automatic stop_test();
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic sig(input int sel, input int ax);
        return (sel == 0) ? servo_enable[ax] : nc_status.active;
    endfunction

    // Bounded wait; a lapse ends the run
    task automatic wait_sig(input int sel, input int ax, input logic val,
                            input int lim, output int n);
        n = 0;
        while (sig(sel, ax) !== val && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        if (sig(sel, ax) !== val) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, sig(sel, ax), val);
            stop_test();
        end
    endtask

    task automatic set_speed(input int ax, input logic [SW-1:0] v);
        @(posedge sys_clk);
        spd_set[ax] <= v;
        spd_load[ax] <= 1'b1;
        @(posedge sys_clk);
        spd_load <= '0;
    endtask

    task automatic ticks(input int k);
        repeat (k * TD) @(negedge sys_clk);
    endtask

    // =======================================================
    // Main sequence
    initial begin
        int n;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(nc_status, 32'h6);
        set_speed(1, 16'hfc18);
        @(posedge sys_clk) en_req <= 4'hf;
        for (int a = 0; a < NA; a++)
            wait_sig(0, a, 1'b1, 40, n);
        @(posedge sys_clk) en_req[0] <= 1'b0;
        wait_sig(0, 0, 1'b0, 8, n);
        chk(delay_running[0], 1'b0);
        // Reversing axis runs the full default delay
        @(posedge sys_clk) en_req[1] <= 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(delay_running[1], 1'b1);
        wait_sig(0, 1, 1'b0, 500, n);
        chk(n + 6 >= 99 * TD && n + 6 <= 101 * TD + 8, 1'b1);
        chk(setpoint_zero[1], 1'b1);
        chk(delay_running[1], 1'b0);
        @(posedge sys_clk) en_req[1:0] <= 2'h3;
        wait_sig(0, 1, 1'b1, 40, n);
        chk(setpoint_zero[1], 1'b0);
        // Ramp shorter than the delay: standstill ends it early
        set_speed(3, 16'h00c8);
        @(posedge sys_clk) fault[3] <= 1'b1;
        wait_sig(0, 3, 1'b0, 200, n);
        chk(n > 15 * TD && n < 30 * TD, 1'b1);
        chk(setpoint_zero[3], 1'b0);
        @(posedge sys_clk) fault[3] <= 1'b0;
        wait_sig(0, 3, 1'b1, 40, n);
        // Low value clamps; later value waits for apply
        @(posedge sys_clk) cfg_ms <= 20'h00005;
        @(posedge sys_clk) config_apply <= 1'b1;
        @(posedge sys_clk) config_apply <= 1'b0;
        cfg_ms <= 20'h001f4;
        set_speed(2, 16'h0400);
        @(posedge sys_clk) fault[2] <= 1'b1;
        wait_sig(0, 2, 1'b0, 200, n);
        chk(n >= 19 * TD && n <= 21 * TD + 8, 1'b1);
        chk(setpoint_zero[2], 1'b1);
        @(posedge sys_clk) fault[2] <= 1'b0;
        wait_sig(0, 2, 1'b1, 40, n);
        // Emergency stop entry, hold and clearing
        @(posedge sys_clk) plc.request <= 1'b1;
        wait_sig(1, 0, 1'b1, 40, n);
        chk(nc_status, 32'h9);
        chk(program_interrupt, 1'b1);
        repeat (4) @(negedge sys_clk);
        chk(servo_enable, 32'h0);
        @(posedge sys_clk) plc.request <= 1'b0;
        ticks(10);
        chk(nc_status.active, 1'b1);
        @(posedge sys_clk) plc.reset <= 1'b1;
        ticks(10);
        chk(nc_status.active, 1'b1);
        @(posedge sys_clk) plc.reset <= 1'b0;
        @(posedge sys_clk) plc.acknowledge <= 1'b1;
        ticks(4);
        @(posedge sys_clk) plc.reset <= 1'b1;
        wait_sig(1, 0, 1'b0, 40, n);
        chk(nc_status, 32'h6);
        chk(program_abort, 1'b1);
        @(posedge sys_clk) plc <= '0;
        wait_sig(0, 0, 1'b1, 40, n);
        chk(servo_enable, 32'hf);
        stop_test();
    end
endmodule
`default_nettype wire
